// ===== hdl/aip_top.sv
// aip_top: post-processing of one analog input channel: scaling, range
// clamp, filter, limit compare and output formatting, plus its registers.
// assumes ADC samples, register requests and the process-data sink all
// run on REF_CLK_I; the ADC converts when CONV_START_O pulses.
`timescale 1ns/1ps
module aip_top
	import aip_pkg::*;
#(
	parameter int CONV_CYC = CONV_CYCLES,
	parameter int WDOG_CYC = WDOG_CYCLES
) (
	input  wire logic        REF_CLK_I,
	input  wire logic        SYS_RST_I,
	input  wire logic [15:0] ADC_DATA_I,
	input  wire logic        ADC_VALID_I,
	output logic             ADC_READY_O,
	output logic             CONV_START_O,
	input  wire logic [5:0]  REG_ADDR_I,
	input  wire logic [15:0] REG_WDATA_I,
	input  wire logic        REG_WR_I,
	input  wire logic        REG_RD_I,
	output logic [15:0]      REG_RDATA_O,
	output logic             REG_ACK_O,
	output logic [15:0]      PD_DATA_O,
	output logic [7:0]       PD_STATUS_O,
	output logic             PD_VALID_O,
	input  wire logic        PD_READY_I
);
	// straight line y = g*x/2^sh + b, saturated to 16 signed bits
	function automatic logic signed [15:0] aip_line(
		input logic signed [15:0] x,
		input logic signed [15:0] g,
		input logic signed [15:0] b,
		input int                 sh
	);
		logic signed [31:0] p;
		logic signed [32:0] s;
		p = x * g;
		s = 33'(p >>> sh) + 33'(b);
		if (s > 33'sd32767)
			aip_line = 16'sh7FFF;
		else if (s < -33'sd32768)
			aip_line = 16'sh8000;
		else
			aip_line = s[15:0];
	endfunction : aip_line

	// limit compare: 00 off, 01 below, 10 above, 11 equal
	function automatic logic [1:0] aip_cmp(
		input logic signed [15:0] v,
		input logic signed [15:0] lim,
		input logic               en
	);
		if (!en)
			aip_cmp = 2'b00;
		else if (v < lim)
			aip_cmp = 2'b01;
		else if (v > lim)
			aip_cmp = 2'b10;
		else
			aip_cmp = 2'b11;
	endfunction : aip_cmp

	logic [15:0]        mode_reg, code_word_reg, filter_reg;
	logic signed [15:0] user_offset_reg, user_gain_term_reg;
	logic signed [15:0] limit1_reg, limit2_reg;
	logic [31:0]        conv_cnt_reg, wdog_cnt_reg;
	logic               wdog_err_reg;
	logic               s_vld_reg, s_over_reg, s_under_reg, s_wdog_reg;
	logic signed [15:0] s_data_reg;
	logic               f_over_reg, f_under_reg, f_wdog_reg;
	logic               f_vld;
	logic signed [15:0] f_data;
	logic               fifo_out_valid;
	logic [23:0]        fifo_out_data;
	logic [2:0]         fifo_count;
	logic               fifo_in_ready;

	// register access decode
	wire unlocked  = code_word_reg == CODE_WORD;
	wire user_area = REG_ADDR_I >= ADDR_MODE && REG_ADDR_I <= ADDR_FILTER;
	wire user_wr   = REG_WR_I && unlocked && user_area;
	wire cw_wr     = REG_WR_I && REG_ADDR_I == ADDR_CODE_WORD;
	wire [15:0] rd_mux =
		(REG_ADDR_I == ADDR_CODE_WORD)   ? (unlocked ? code_word_reg : 16'h0000) :
		(REG_ADDR_I == ADDR_MODE)        ? mode_reg :
		(REG_ADDR_I == ADDR_USER_OFFSET) ? user_offset_reg :
		(REG_ADDR_I == ADDR_USER_GAIN)   ? user_gain_term_reg :
		(REG_ADDR_I == ADDR_LIMIT1)      ? limit1_reg :
		(REG_ADDR_I == ADDR_LIMIT2)      ? limit2_reg :
		(REG_ADDR_I == ADDR_FILTER)      ? filter_reg : 16'h0000;

	// register file; reserved mode bits are stored as written
	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			mode_reg           <= MODE_RESET;
			user_offset_reg    <= USER_OFFSET_RST;
			user_gain_term_reg <= USER_GAIN_RST;
			limit1_reg         <= LIMIT_RST;
			limit2_reg         <= LIMIT_RST;
			filter_reg         <= FILTER_RESET;
			code_word_reg      <= 16'h0000;
		end
		else
		begin
			if (cw_wr)
				code_word_reg <= REG_WDATA_I;
			if (user_wr && REG_ADDR_I == ADDR_MODE)
				mode_reg <= REG_WDATA_I;
			if (user_wr && REG_ADDR_I == ADDR_USER_OFFSET)
				user_offset_reg <= REG_WDATA_I;
			if (user_wr && REG_ADDR_I == ADDR_USER_GAIN)
				user_gain_term_reg <= REG_WDATA_I;
			if (user_wr && REG_ADDR_I == ADDR_LIMIT1)
				limit1_reg <= REG_WDATA_I;
			if (user_wr && REG_ADDR_I == ADDR_LIMIT2)
				limit2_reg <= REG_WDATA_I;
			if (user_wr && REG_ADDR_I == ADDR_FILTER)
				filter_reg <= REG_WDATA_I;
		end
	end

	// every request is acknowledged next cycle, even a refused write
	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			REG_ACK_O   <= 1'b0;
			REG_RDATA_O <= 16'h0000;
		end
		else
		begin
			REG_ACK_O <= REG_WR_I || REG_RD_I;
			if (REG_RD_I)
				REG_RDATA_O <= rd_mux;
		end
	end

	// conversion pacing; single channel, so it is its own notch timebase
	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			conv_cnt_reg <= '0;
			CONV_START_O <= 1'b0;
		end
		else
		begin
			CONV_START_O <= conv_cnt_reg == 32'(CONV_CYC - 1);
			conv_cnt_reg <= (conv_cnt_reg == 32'(CONV_CYC - 1)) ? '0 : conv_cnt_reg + 32'd1;
		end
	end

	// sample path front: manufacturer line, user line, range clamp
	wire adc_take = ADC_VALID_I && ADC_READY_O;
	wire signed [15:0] adc_x = ADC_DATA_I;
	wire signed [15:0] mfr_y = mode_reg[MB_MFR_SCALE] ?
		aip_line(adc_x, MFR_GAIN, MFR_OFFSET, MFR_SHIFT) : adc_x;
	wire signed [15:0] user_y = mode_reg[MB_USER_SCALE] ?
		aip_line(mfr_y, user_gain_term_reg, user_offset_reg, USER_SHIFT) : mfr_y;
	wire over_rng  = mode_reg[MB_RANGE_PROT] && user_y > $signed(UPPER_RANGE_LIMIT);
	wire under_rng = mode_reg[MB_RANGE_PROT] && user_y < $signed(LOWER_RANGE_LIMIT);
	wire signed [15:0] clamp_y = over_rng ? UPPER_RANGE_LIMIT :
		under_rng ? LOWER_RANGE_LIMIT : user_y;

	// stage register before the filter
	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			s_vld_reg   <= 1'b0;
			s_data_reg  <= '0;
			s_over_reg  <= 1'b0;
			s_under_reg <= 1'b0;
			f_over_reg  <= 1'b0;
			f_under_reg <= 1'b0;
			s_wdog_reg  <= 1'b0;
			f_wdog_reg  <= 1'b0;
		end
		else
		begin
			s_vld_reg <= adc_take;
			if (adc_take)
			begin
				s_data_reg  <= clamp_y;
				s_over_reg  <= over_rng;
				s_under_reg <= under_rng;
				s_wdog_reg  <= wdog_err_reg;
			end
			// range flags ride alongside the one-cycle filter latency
			if (s_vld_reg)
			begin
				f_over_reg  <= s_over_reg;
				f_under_reg <= s_under_reg;
				f_wdog_reg  <= s_wdog_reg;
			end
		end
	end

	aip_sample_filter u_filt (
		.clk_i       (REF_CLK_I),
		.rst_i       (SYS_RST_I),
		.in_valid_i  (s_vld_reg),
		.in_data_i   (s_data_reg),
		.enable_i    (mode_reg[FILTER_ENABLE_BIT]),
		.code_i      (filter_reg),
		.out_valid_o (f_vld),
		.out_data_o  (f_data)
	);

	// watchdog: flags an error when samples stop arriving
	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			wdog_cnt_reg <= '0;
			wdog_err_reg <= 1'b0;
		end
		else if (!mode_reg[MB_WATCHDOG] || adc_take)
		begin
			wdog_cnt_reg <= '0;
			wdog_err_reg <= 1'b0;
		end
		else if (wdog_cnt_reg == 32'(WDOG_CYC - 1))
			wdog_err_reg <= 1'b1;
		else
			wdog_cnt_reg <= wdog_cnt_reg + 32'd1;
	end

	// output formatting and status byte
	wire [1:0] lim1_st = aip_cmp(f_data, limit1_reg, mode_reg[MB_LIMIT1]);
	wire [1:0] lim2_st = aip_cmp(f_data, limit2_reg, mode_reg[MB_LIMIT2]);
	// the late sample carries the error, since its own take clears the flag
	wire [7:0] status = {1'b0, f_wdog_reg, lim2_st, lim1_st, f_over_reg, f_under_reg};
	// -32768 has no magnitude form; it saturates to full negative scale
	wire [15:0] mag    = (f_data == 16'sh8000) ? 16'h7FFF : 16'(-f_data);
	wire [15:0] sm_y   = (mode_reg[MB_SIGN_MAG] && f_data[15]) ?
		{1'b1, mag[14:0]} : f_data;
	// controller programs user terms for this format's scaling
	wire [15:0] fmt_y  = mode_reg[MB_LOW_STATUS] ?
		{sm_y[15:3], 2'b00, f_over_reg} : sm_y;

	// room is reserved for samples already in flight so none is lost
	wire [3:0] occupied = 4'(fifo_count) + 4'(s_vld_reg) + 4'(f_vld) + 4'(adc_take);
	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
			ADC_READY_O <= 1'b0;
		else
			ADC_READY_O <= occupied < 4'(FIFO_DEPTH);
	end

	aip_fifo #(
		.W (FIFO_WIDTH),
		.D (FIFO_DEPTH)
	) u_fifo (
		.clk_i       (REF_CLK_I),
		.rst_i       (SYS_RST_I),
		.in_valid_i  (f_vld),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   ({status, fmt_y}),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (!PD_VALID_O || PD_READY_I),
		.out_data_o  (fifo_out_data),
		.count_o     (fifo_count)
	);

	// output holding register keeps the ports straight from flops
	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			PD_VALID_O  <= 1'b0;
			PD_DATA_O   <= 16'h0000;
			PD_STATUS_O <= 8'h00;
		end
		else if (!PD_VALID_O || PD_READY_I)
		begin
			PD_VALID_O  <= fifo_out_valid;
			PD_DATA_O   <= fifo_out_data[15:0];
			PD_STATUS_O <= fifo_out_data[23:16];
		end
	end

	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (SYS_RST_I);

	sequence locked_mode_wr;
		REG_WR_I && !unlocked && REG_ADDR_I == ADDR_MODE;
	endsequence
	sequence bad_cw_wr;
		REG_WR_I && REG_ADDR_I == ADDR_CODE_WORD && REG_WDATA_I != CODE_WORD;
	endsequence

	mode_lock_a: assert property (locked_mode_wr |=> $stable(mode_reg))
		else $error("mode register written while locked");
	relock_a: assert property (bad_cw_wr ##[1:2] locked_mode_wr |=> $stable(mode_reg))
		else $error("wrong code word did not relock");
	reg_ack_a: assert property ((REG_WR_I || REG_RD_I) |=> REG_ACK_O)
		else $error("register request not acknowledged");
	clamp_hi_a: assert property (adc_take && over_rng |=>
		s_data_reg == UPPER_RANGE_LIMIT && s_over_reg)
		else $error("over range sample not clamped");
	clamp_lo_a: assert property (adc_take && under_rng |=>
		s_data_reg == LOWER_RANGE_LIMIT && s_under_reg)
		else $error("under range sample not clamped");
	low_fmt_a: assert property (f_vld && mode_reg[MB_LOW_STATUS] |->
		fmt_y[2:0] == {2'b00, f_over_reg})
		else $error("low status bits wrong");
	lim_off_a: assert property (f_vld && !mode_reg[MB_LIMIT1] && !mode_reg[MB_LIMIT2] |->
		status[5:2] == 4'h0)
		else $error("disabled limit reported status");
	sign_mag_a: assert property (f_vld && mode_reg[MB_SIGN_MAG] && !mode_reg[MB_LOW_STATUS]
		&& f_data == -16'sd1 |-> fmt_y == 16'h8001)
		else $error("minus one not 0x8001");
	conv_gap_a: assert property (CONV_START_O |=> !CONV_START_O)
		else $error("conversion pulses back to back");
	user_line_a: assert property (adc_take && !mode_reg[MB_MFR_SCALE]
		&& !mode_reg[MB_USER_SCALE] && !mode_reg[MB_RANGE_PROT] |=> s_data_reg == $past(adc_x))
		else $error("disabled scaling altered sample");
	fifo_room_a: assert property (f_vld |-> fifo_in_ready)
		else $error("filtered sample met a full buffer");
	wdog_off_a: assert property (!mode_reg[MB_WATCHDOG] |=> !wdog_err_reg)
		else $error("watchdog error while watchdog disabled");
endmodule : aip_top

// ===== hdl/aip_pkg.sv
// aip_pkg: register map, mode bits, status layout and timing constants
// for the analog input post-processing block; shared by aip_top, aip_sample_filter and the testbench.
package aip_pkg;
	// register addresses (6-bit register number space)
	localparam logic [5:0]  ADDR_CODE_WORD   = 6'h1F;
	localparam logic [5:0]  ADDR_MODE        = 6'h20;
	localparam logic [5:0]  ADDR_USER_OFFSET = 6'h21;
	localparam logic [5:0]  ADDR_USER_GAIN   = 6'h22;
	localparam logic [5:0]  ADDR_LIMIT1      = 6'h23;
	localparam logic [5:0]  ADDR_LIMIT2      = 6'h24;
	localparam logic [5:0]  ADDR_FILTER      = 6'h25;
	// reset values and the unlock code word
	localparam logic [15:0] MODE_RESET       = 16'h1106;
	localparam logic [15:0] USER_OFFSET_RST  = 16'h0000;
	localparam logic [15:0] USER_GAIN_RST    = 16'h0100;
	localparam logic [15:0] LIMIT_RST        = 16'h0000;
	localparam logic [15:0] FILTER_RESET     = 16'h0000;
	localparam logic [15:0] CODE_WORD        = 16'h1235;
	// operation-mode bit positions
	localparam int MB_USER_SCALE   = 0;
	localparam int MB_MFR_SCALE    = 1;
	localparam int MB_WATCHDOG     = 2;
	localparam int MB_SIGN_MAG     = 3;
	localparam int MB_LOW_STATUS   = 4;
	localparam int MB_RANGE_PROT   = 8;
	localparam int MB_LIMIT1       = 9;
	localparam int MB_LIMIT2       = 10;
	localparam int FILTER_ENABLE_BIT = 11;
	// fixed scaling and range constants
	localparam logic [15:0] MFR_GAIN          = 16'h2002;
	localparam logic [15:0] MFR_OFFSET        = 16'h0000;
	localparam int          MFR_SHIFT         = 10;
	localparam int          USER_SHIFT        = 8;
	localparam logic [15:0] UPPER_RANGE_LIMIT = 16'h0FFF;
	localparam logic [15:0] LOWER_RANGE_LIMIT = 16'h0000;
	// filter codes
	localparam logic [15:0] FILT_FIR2   = 16'h0000;
	localparam logic [15:0] FILT_IIR_LO = 16'h0100;
	localparam logic [15:0] FILT_IIR_HI = 16'h0700;
	localparam logic [15:0] FILT_AVG50  = 16'h1000;
	localparam logic [15:0] FILT_AVG60  = 16'h2000;
	localparam int          AVG_LEN     = 16;
	// status byte bit positions
	localparam int ST_UNDER = 0;
	localparam int ST_OVER  = 1;
	localparam int ST_LIM1  = 2;
	localparam int ST_LIM2  = 4;
	localparam int ST_ERROR = 6;
	// timing
	localparam int CLK_PERIOD_PS = 4000;
	localparam int CONV_TIME_US  = 2500;
	// divide before the last scaling step so the product stays inside 32 bits
	localparam int CONV_CYCLES   = CONV_TIME_US * 1000 / CLK_PERIOD_PS * 1000;
	localparam int WDOG_TIME_MS  = 100;
	localparam int WDOG_CYCLES   = WDOG_TIME_MS * 1000 * 1000 / CLK_PERIOD_PS * 1000;
	localparam int FIFO_DEPTH    = 4;
	localparam int FIFO_WIDTH    = 24;
endpackage : aip_pkg

// ===== hdl/aip_fifo.sv
// aip_fifo: small synchronous FIFO with valid/ready on both sides.
// assumes one clock; count is exposed so the source can reserve room.
`timescale 1ns/1ps
module aip_fifo #(
	parameter int W = 24,
	parameter int D = 4
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o,
	output logic [$clog2(D):0] count_o
);
	localparam int         AW = $clog2(D);
	logic [W-1:0]          mem [D];
	logic [$clog2(D)-1:0]  wr_ptr_reg;
	logic [$clog2(D)-1:0]  rd_ptr_reg;
	logic [$clog2(D):0]    count_reg;
	wire                   push = in_valid_i && in_ready_o;
	wire                   pop  = out_valid_o && out_ready_i;

	// honest flags straight from the occupancy count
	assign in_ready_o  = count_reg < ($clog2(D)+1)'(D);
	assign out_valid_o = count_reg != '0;
	assign out_data_o  = mem[rd_ptr_reg];
	assign count_o     = count_reg;

	// storage needs no reset: empty slots are never read out
	always_ff @(posedge clk_i)
	begin
		if (push)
			mem[wr_ptr_reg] <= in_data_i;
	end

	// pointers wrap naturally because the depth is a power of two
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else
		begin
			wr_ptr_reg <= wr_ptr_reg + AW'(push);
			rd_ptr_reg <= rd_ptr_reg + AW'(pop);
			count_reg  <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : aip_fifo

// ===== hdl/aip_sample_filter.sv
// aip_sample_filter: selectable FIR / IIR / 16-value averaging filter.
// one sample in, one sample out exactly one clock later.
`timescale 1ns/1ps
module aip_sample_filter
	import aip_pkg::*;
(
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire logic               in_valid_i,
	input  wire logic signed [15:0] in_data_i,
	input  wire logic               enable_i,
	input  wire logic [15:0]        code_i,
	output logic                    out_valid_o,
	output logic signed [15:0]      out_data_o
);
	logic signed [15:0] x1_reg, x2_reg, iir_reg;
	logic signed [15:0] hist [AVG_LEN];
	logic [3:0]         idx_reg;
	logic signed [19:0] sum_reg;

	// code decode
	wire is_fir = code_i == FILT_FIR2;
	wire is_iir = code_i >= FILT_IIR_LO && code_i <= FILT_IIR_HI && code_i[7:0] == 8'h00;
	wire is_avg = code_i == FILT_AVG50 || code_i == FILT_AVG60;
	// longer shift means lower cut-off; 1 kHz .. 1 Hz map to shifts 1..9
	wire [3:0] iir_k = (code_i[10:8] == 3'd7) ? 4'd9 : 4'({1'b0, code_i[10:8]}) + 4'd0;
	wire signed [17:0] fir_y = 18'(in_data_i) + 18'(x1_reg) * 18'sd2 + 18'(x2_reg);
	wire signed [16:0] iir_d = 17'(in_data_i) - 17'(iir_reg);
	wire signed [15:0] iir_y = iir_reg + 16'(iir_d >>> iir_k);
	wire signed [19:0] sum_y = sum_reg + 20'(in_data_i) - 20'(hist[idx_reg]);
	wire signed [15:0] filt_y = !enable_i ? in_data_i :
		is_fir ? 16'(fir_y >>> 2) :
		is_iir ? iir_y :
		is_avg ? 16'(sum_y >>> 4) : in_data_i;

	// history and state update on every accepted sample
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			x1_reg      <= '0;
			x2_reg      <= '0;
			iir_reg     <= '0;
			idx_reg     <= '0;
			sum_reg     <= '0;
			out_valid_o <= 1'b0;
			out_data_o  <= '0;
		end
		else
		begin
			out_valid_o <= in_valid_i;
			if (in_valid_i)
			begin
				x1_reg     <= in_data_i;
				x2_reg     <= x1_reg;
				iir_reg    <= iir_y;
				sum_reg    <= sum_y;
				idx_reg    <= idx_reg + 4'd1;
				out_data_o <= filt_y;
			end
		end
	end

	// averaging window; cleared by reset so the first sums are defined
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			hist <= '{default: '0};
		else if (in_valid_i)
			hist[idx_reg] <= in_data_i;
	end

	filt_bypass_a: assert property (@(posedge clk_i) disable iff (rst_i)
		in_valid_i && enable_i && !is_fir && !is_iir && !is_avg
		|=> out_valid_o && out_data_o == $past(in_data_i))
		else $error("undefined filter code did not bypass");
endmodule : aip_sample_filter

// ===== tb/aip_coupler_model.sv
// aip_coupler_model: coupler side of the process-data stream; collects
// {status,data} words in arrival order and can hold off the block.
// assumes one clock shared with the block; ready changes on falling edges.
`timescale 1ns/1ps
module aip_coupler_model (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [15:0] pd_data_i,
	input  wire logic [7:0]  pd_status_i,
	input  wire logic        pd_valid_i,
	input  wire logic        stall_i,
	output logic             pd_ready_o
);
	logic [23:0] rx_q[$];

	// ready moves off the sampling edge so the take is never racy
	initial pd_ready_o = 1'b0;
	always @(negedge clk_i)
		pd_ready_o <= !stall_i && !rst_i;

	// a word is taken only where valid and ready meet at a rising edge
	always @(posedge clk_i)
		if (!rst_i && pd_valid_i === 1'b1 && pd_ready_o)
			rx_q.push_back({pd_status_i, pd_data_i});
endmodule : aip_coupler_model

// ===== tb/testbench.sv
// testbench: register, scaling, format, limit, filter and buffer checks.
// assumes short test counts for conversion period and watchdog.
`timescale 1ns/1ps
`define CHK(g, e) \
	begin total_checks++; if ((g) !== (e)) begin err_total++; \
	$display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module testbench;
	import aip_pkg::*;
	logic        clk = 0, rst = 1, vld = 0, wr_s = 0, rd_s = 0, stall = 0;
	logic [15:0] adc = 0, wdata = 0, rdata, pd_d;
	logic [5:0]  addr = 0;
	logic [7:0]  pd_s;
	logic        rdy, conv, ack, pd_v, pd_r;
	int          err_total = 0, total_checks = 0, cyc = 0;

	aip_top #(.CONV_CYC(20), .WDOG_CYC(50)) u_dut (.REF_CLK_I(clk), .SYS_RST_I(rst),
		.ADC_DATA_I(adc), .ADC_VALID_I(vld), .ADC_READY_O(rdy), .CONV_START_O(conv),
		.REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr_s), .REG_RD_I(rd_s),
		.REG_RDATA_O(rdata), .REG_ACK_O(ack), .PD_DATA_O(pd_d), .PD_STATUS_O(pd_s),
		.PD_VALID_O(pd_v), .PD_READY_I(pd_r));
	aip_coupler_model u_cpl (.clk_i(clk), .rst_i(rst), .pd_data_i(pd_d),
		.pd_status_i(pd_s), .pd_valid_i(pd_v), .stall_i(stall), .pd_ready_o(pd_r));

	always #2 clk = ~clk;

	// hang guard: the whole run needs under a thousand cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			err_total++;
			end_of_test();
		end
	end

	task end_of_test;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test

	// one-cycle strobes, as the bus takes them
	task wr(input logic [5:0] a, input logic [15:0] d);
		@(negedge clk) {addr, wdata, wr_s} = {a, d, 1'b1};
		@(negedge clk) wr_s = 0;
	endtask : wr

	task rd(input logic [5:0] a, input logic [15:0] e);
		@(negedge clk) {addr, rd_s} = {a, 1'b1};
		@(negedge clk) rd_s = 0;
		`CHK(ack, 1'b1)
		`CHK(rdata, e)
	endtask : rd

	task put(input logic [15:0] d);
		int n;
		n = 0;
		@(negedge clk);
		while (rdy !== 1'b1 && n < 100)
		begin
			n++;
			@(negedge clk);
		end
		{adc, vld} = {d, 1'b1};
		@(negedge clk) vld = 0;
	endtask : put

	// pops the next collected word; chk=0 only drains settling values
	task take(input logic [15:0] d, input logic [7:0] s, input bit chk = 1);
		int n;
		logic [23:0] w;
		n = 0;
		while (u_cpl.rx_q.size() == 0 && n < 100)
		begin
			n++;
			@(negedge clk);
		end
		w = (u_cpl.rx_q.size() > 0) ? u_cpl.rx_q.pop_front() : 24'hx;
		if (chk)
			`CHK(w, {s, d})
	endtask : take

	task feed(input int k, input logic [15:0] d);
		repeat (k)
		begin
			put(d);
			take(d, 8'h00, 0);
		end
	endtask : feed

	task t_regs;
		rd(ADDR_MODE, 16'h1106);
		rd(ADDR_FILTER, 16'h0000);
		rd(ADDR_CODE_WORD, 16'h0000);
		wr(ADDR_MODE, 16'h1000);
		rd(ADDR_MODE, 16'h1106);
		rd(6'h3A, 16'h0000);
		wr(ADDR_CODE_WORD, 16'h1235);
		rd(ADDR_CODE_WORD, 16'h1235);
		wr(ADDR_CODE_WORD, 16'h0001);
		wr(ADDR_MODE, 16'h1000);
		rd(ADDR_MODE, 16'h1106);
		rd(ADDR_CODE_WORD, 16'h0000);
		wr(ADDR_CODE_WORD, 16'h1235);
	endtask : t_regs

	task t_range;
		wr(ADDR_MODE, 16'h1000);
		put(16'h2000);
		take(16'h2000, 8'h00);
		wr(ADDR_MODE, 16'h1100);
		put(16'h2000);
		take(16'h0FFF, 8'h02);
		put(16'hFFFB);
		take(16'h0000, 8'h01);
		put(16'h0FFF);
		take(16'h0FFF, 8'h00);
	endtask : t_range

	task t_user;
		wr(ADDR_MODE, 16'h1002);
		put(16'h0400);
		take(16'h2002, 8'h00);
		wr(ADDR_USER_GAIN, 16'h0200);
		wr(ADDR_USER_OFFSET, 16'hFFFD);
		wr(ADDR_MODE, 16'h1001);
		put(16'd100);
		take(16'd197, 8'h00);
		wr(ADDR_USER_GAIN, 16'h0080);
		put(16'd8);
		take(16'd1, 8'h00);
		wr(ADDR_USER_GAIN, 16'h7FFF);
		wr(ADDR_USER_OFFSET, 16'h7FFF);
		put(16'h7FFF);
		take(16'h7FFF, 8'h00);
	endtask : t_user

	task t_fmt;
		wr(ADDR_MODE, 16'h1008);
		put(16'hFFFF);
		take(16'h8001, 8'h00);
		wr(ADDR_MODE, 16'h1110);
		put(16'h2000);
		take(16'h0FF9, 8'h02);
		put(16'h0100);
		take(16'h0100, 8'h00);
		// low-bit format gets its scaling only from the user terms
		wr(ADDR_USER_GAIN, 16'h0080);
		wr(ADDR_USER_OFFSET, 16'h0000);
		wr(ADDR_MODE, 16'h1111);
		put(16'h0200);
		take(16'h0100, 8'h00);
	endtask : t_fmt

	task t_limit;
		wr(ADDR_LIMIT1, 16'd50);
		wr(ADDR_LIMIT2, 16'd60);
		wr(ADDR_MODE, 16'h1600);
		put(16'd40);
		take(16'd40, 8'h14);
		put(16'd50);
		take(16'd50, 8'h1C);
		put(16'd60);
		take(16'd60, 8'h38);
		put(16'd70);
		take(16'd70, 8'h28);
		wr(ADDR_MODE, 16'h1200);
		put(16'd70);
		take(16'd70, 8'h08);
	endtask : t_limit

	// a gap longer than the watchdog time marks only the next word
	task t_wdog;
		wr(ADDR_MODE, 16'h1004);
		repeat (60) @(negedge clk);
		put(16'd5);
		take(16'd5, 8'h40);
		put(16'd6);
		take(16'd6, 8'h00);
		wr(ADDR_MODE, 16'h1000);
	endtask : t_wdog

	// a constant run settles every averaging window to that constant
	task t_filt;
		wr(ADDR_MODE, 16'h1800);
		wr(ADDR_FILTER, 16'h1000);
		feed(15, 16'd40);
		put(16'd40);
		take(16'd40, 8'h00);
		wr(ADDR_FILTER, 16'h2000);
		feed(15, 16'd24);
		put(16'd24);
		take(16'd24, 8'h00);
		wr(ADDR_FILTER, 16'h0000);
		feed(2, 16'd40);
		put(16'd80);
		take(16'd50, 8'h00);
		wr(ADDR_FILTER, 16'h0800);
		put(16'd7);
		take(16'd7, 8'h00);
		// a run of zeros settles the recursive filter to zero exactly
		wr(ADDR_FILTER, 16'h0100);
		feed(16, 16'd0);
		put(16'd64);
		take(16'd32, 8'h00);
		wr(ADDR_FILTER, 16'h0700);
		put(16'd1056);
		take(16'd34, 8'h00);
		wr(ADDR_MODE, 16'h1000);
		put(16'd9);
		take(16'd9, 8'h00);
	endtask : t_filt

	// sink stalls: four words buffer, one waits at the port, then input is refused
	task t_fifo;
		stall = 1;
		for (int i = 1; i <= 5; i++)
			put(16'(i));
		repeat (6) @(negedge clk);
		`CHK(rdy, 1'b0)
		`CHK(pd_v, 1'b1)
		`CHK(pd_d, 16'd1)
		stall = 0;
		for (int i = 1; i <= 5; i++)
			take(16'(i), 8'h00);
	endtask : t_fifo

	task t_conv;
		int n;
		n = 0;
		while (conv !== 1'b1 && n < 100)
		begin
			n++;
			@(negedge clk);
		end
		n = 0;
		@(negedge clk);
		while (conv !== 1'b1 && n < 100)
		begin
			n++;
			@(negedge clk);
		end
		`CHK(n + 1, 20)
	endtask : t_conv

	initial
	begin
		repeat (3) @(negedge clk);
		rst = 0;
		t_regs();
		t_range();
		t_user();
		t_fmt();
		t_limit();
		t_wdog();
		t_filt();
		t_fifo();
		t_conv();
		end_of_test();
	end
endmodule : testbench
